// ==== hw/trace_entry_formatter.sv ====
// trace entry formatter: register port, bus monitors, line output
`timescale 1ns/10ps
`default_nettype none
module trace_entry_formatter #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [trace_fmt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [trace_fmt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [trace_fmt_pkg::DATA_W-1:0] reg_rdata,
  // cpu bus monitor
  input wire logic [trace_fmt_pkg::CPU_AW-1:0] cpu_pc,
  input wire logic cpu_change_of_flow,
  input wire logic cpu_dest,
  input wire logic cpu_vector,
  input wire logic cpu_free,
  input wire logic cpu_opcode_fetch,
  input wire logic [trace_fmt_pkg::CPU_AW-1:0] cpu_addr,
  input wire logic cpu_access_size,
  input wire logic cpu_read_write,
  input wire logic [15:0] cpu_data,
  // coprocessor bus monitor
  input wire logic [trace_fmt_pkg::COP_AW-1:0] cop_pc,
  input wire logic cop_change_of_flow,
  input wire logic cop_dest,
  input wire logic cop_vector,
  input wire logic cop_bus_ack,
  input wire logic cop_opcode_fetch,
  input wire logic [trace_fmt_pkg::COP_AW-1:0] cop_addr,
  input wire logic cop_access_size,
  input wire logic cop_read_write,
  input wire logic [15:0] cop_data,
  // trace buffer side
  output logic [trace_fmt_pkg::LINE_W-1:0] trace_line,
  output logic trace_line_wr,
  output logic [CNT_W-1:0] trace_entry_counter
);
  import trace_fmt_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [LINE_W-1:0] line_q;
  logic line_wr_q;
  logic [DATA_W-1:0] rdata_q;
  logic [CPU_AW-1:0] last_cpu_pc_q;
  logic [COP_AW-1:0] last_cop_pc_q;

  trace_entry_if ent ();

  // register decode
  wire ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  wire cnt_clr = ctrl_wr && reg_wdata[CTRL_CLR_BIT];
  wire hit_ctrl = reg_addr == CTRL_OFS;
  wire hit_count = reg_addr == COUNT_OFS;
  wire hit_lo = reg_addr == LINE_LO_OFS;
  wire hit_hi = reg_addr == LINE_HI_OFS;

  // control fields
  wire trace_on = ctrl_q[CTRL_EN_BIT];
  wire trace_mode_type mode =
    trace_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
  wire trace_cpu = ctrl_q[CTRL_CPU_BIT];
  wire trace_cop = ctrl_q[CTRL_COP_BIT];
  wire detail = mode == MODE_DETAIL;
  wire loop_trace_mode = mode == MODE_LOOP;
  wire both = trace_cpu && trace_cop;

  // loop mode drops a repeat of the last stored flow target,
  // so a tight loop does not flood the buffer
  wire cpu_repeat = loop_trace_mode && (cpu_pc == last_cpu_pc_q);
  wire cop_repeat = loop_trace_mode && (cop_pc == last_cop_pc_q);
  wire cpu_hit = trace_on && !detail && trace_cpu &&
    cpu_change_of_flow && !cpu_repeat;
  wire cop_hit = trace_on && !detail && trace_cop &&
    cop_change_of_flow && !cop_repeat;

  // detail captures; cpu wins when both sources are selected
  wire det_cpu = trace_on && detail && trace_cpu &&
    !cpu_free && !cpu_opcode_fetch;
  wire det_cop = trace_on && detail && !trace_cpu && trace_cop &&
    cop_bus_ack && !cop_opcode_fetch;

  // line strobes for each form
  wire both_stb = both && (cpu_hit || cop_hit);
  wire single_stb = !both && (cpu_hit || cop_hit);
  wire det_stb = det_cpu || det_cop;

  logic [7:0] cpu_info_byte;
  logic [7:0] cop_info_byte;
  logic [7:0] combined_info_byte;

  info_byte_builder u_info (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode(mode),
    .cpu_dest(cpu_dest),
    .cpu_vector(cpu_vector),
    .cpu_valid(cpu_hit),
    .cpu_free(cpu_free),
    .cpu_access_size(cpu_access_size),
    .cpu_read_write(cpu_read_write),
    .cpu_opcode_fetch(cpu_opcode_fetch),
    .cop_dest(cop_dest),
    .cop_vector(cop_vector),
    .cop_valid(cop_hit),
    .cop_bus_ack(cop_bus_ack),
    .cop_access_size(cop_access_size),
    .cop_read_write(cop_read_write),
    .cop_opcode_fetch(cop_opcode_fetch),
    .cpu_info_byte(cpu_info_byte),
    .cop_info_byte(cop_info_byte),
    .combined_info_byte(combined_info_byte)
  );

  // entry forms; the idle source is a snapshot, valid bit clear
  wire [ENTRY_W-1:0] cpu_entry = {cpu_info_byte, cpu_pc};
  wire [ENTRY_W-1:0] cop_entry = {cop_info_byte, 8'h00, cop_pc};
  wire [LINE_W-1:0] both_line = {cop_entry, cpu_entry};
  wire [LINE_W-1:0] det_cpu_line = {combined_info_byte, cpu_addr,
    data_lanes(cpu_access_size, cpu_data), cop_pc};
  wire [LINE_W-1:0] det_cop_line = {combined_info_byte, cpu_pc,
    data_lanes(cop_access_size, cop_data), cop_addr};

  // single-source entries go through the pair packer
  assign ent.entry = trace_cpu ? cpu_entry : cop_entry;
  assign ent.entry_stb = single_stb;
  assign ent.flush = ctrl_wr;

  pc_pair_packer u_pack (
    .ref_clk(ref_clk),
    .rst(rst),
    .ent(ent)
  );

  // line selection
  wire line_stb = both_stb || det_stb || ent.line_stb;
  wire [LINE_W-1:0] line_d = det_cpu ? det_cpu_line
    : det_cop ? det_cop_line
    : both_stb ? both_line
    : ent.line;

  // counter: detail holds bit0 low and steps by lines
  wire [CNT_W-1:0] cnt_det = {cnt_q[CNT_W-1:1] + 1'b1, 1'b0};
  wire [CNT_W-1:0] cnt_one = cnt_q + 1'b1;
  wire [CNT_W-1:0] cnt_d = cnt_clr ? '0
    : det_stb ? cnt_det
    : (both_stb || single_stb) ? cnt_one
    : cnt_q;

  // read mux; unmapped addresses read zero
  wire [DATA_W-1:0] rd_mux =
    hit_ctrl ? DATA_W'(ctrl_q)
    : hit_count ? DATA_W'(cnt_q)
    : hit_lo ? line_q[DATA_W-1:0]
    : hit_hi ? line_q[LINE_W-1:DATA_W]
    : '0;

  // control register; the clear bit is a pulse, never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  // entry counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // buffer line and its write pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_q <= '0;
      line_wr_q <= 1'b0;
    end else begin
      line_wr_q <= line_stb;
      if (line_stb) begin
        line_q <= line_d;
      end
    end
  end

  // loop history, kept per source
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_cpu_pc_q <= '0;
      last_cop_pc_q <= '0;
    end else begin
      if (cpu_hit) begin
        last_cpu_pc_q <= cpu_pc;
      end
      if (cop_hit) begin
        last_cop_pc_q <= cop_pc;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign trace_line = line_q;
  assign trace_line_wr = line_wr_q;
  assign trace_entry_counter = cnt_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  detail_count_a: assert property ((det_stb && !cnt_clr) |=>
    (cnt_q[0] == 1'b0 &&
    cnt_q[CNT_W-1:1] == $past(cnt_q[CNT_W-1:1]) + 1'b1))
    else $error("detail line did not step the counter by two");

  flow_valid_a: assert property ((both_stb && cpu_hit) |=>
    (trace_line_wr && trace_line[INF_VALID_BIT + 24]))
    else $error("cpu flow line missing or not flagged valid");

  snapshot_pc_a: assert property ((both_stb && !cpu_hit) |=>
    (!trace_line[INF_VALID_BIT + 24] &&
    trace_line[CPU_AW-1:0] == $past(cpu_pc)))
    else $error("cpu snapshot wrong or flagged valid");

  byte_access_a: assert property ((det_cpu && !cpu_access_size) |=>
    (trace_line[31:24] == 8'h00 &&
    trace_line[23:16] == $past(cpu_data[7:0])))
    else $error("byte access not in low data byte");

  word_order_a: assert property ((det_cop && cop_access_size) |=>
    (trace_line[31:16] == $past(cop_data)))
    else $error("word bytes in wrong order");

  detail_layout_a: assert property (det_cpu |=>
    (trace_line[63:56] == $past(combined_info_byte) &&
    trace_line[55:32] == $past(cpu_addr) &&
    trace_line[15:0] == $past(cop_pc)))
    else $error("detail cpu line layout wrong");

  dest_flag_a: assert property ((both_stb && cpu_hit && cpu_dest &&
    mode == MODE_NORMAL) |=> trace_line[INF_SD_BIT + 24])
    else $error("destination flag not set");

  skip_fetch_a: assert property ((detail && trace_cpu &&
    (cpu_free || cpu_opcode_fetch)) |=> !trace_line_wr)
    else $error("fetch or free cycle was stored");

  free_flag_a: assert property (det_cop |=>
    (trace_line[63] == !$past(cpu_free) &&
    trace_line[55:32] == $past(cpu_pc)))
    else $error("cpu free flag or snapshot wrong");

  rd_timing_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  cop_valid_a: assert property ((both_stb && cop_hit) |=>
    (trace_line_wr && trace_line[INF_VALID_BIT + 56]))
    else $error("coprocessor flow line not flagged valid");

  cpu_access_type_a: assert property (det_cpu |=>
    (trace_line[62:61] == $past({cpu_access_size, cpu_read_write}) &&
    trace_line[59] == $past(cop_bus_ack) &&
    trace_line[56] == $past(cop_opcode_fetch)))
    else $error("cpu access type or coprocessor qualifiers wrong");

  cop_access_type_a: assert property (det_cop |=>
    (trace_line[58:57] == $past({cop_access_size, cop_read_write}) &&
    trace_line[60] == $past(cpu_opcode_fetch) &&
    trace_line[15:0] == $past(cop_addr)))
    else $error("coprocessor access type or address wrong");

  skip_cop_idle_a: assert property ((detail && !trace_cpu &&
    (!cop_bus_ack || cop_opcode_fetch)) |=> !trace_line_wr)
    else $error("coprocessor free or fetch cycle was stored");

  pair_write_a: assert property (ent.line_stb |=>
    (trace_line_wr && trace_line[LINE_W-1:ENTRY_W] == $past(ent.entry)))
    else $error("paired line not written with second entry");

  count_clear_a: assert property (cnt_clr |=> cnt_q == '0)
    else $error("counter not cleared by control write");

  both_flow_c: cover property (both_stb && cpu_hit && cop_hit);
  cop_flow_c: cover property (both_stb && cop_hit && !cpu_hit);
  loop_drop_c: cover property (trace_on && cpu_change_of_flow && cpu_repeat);
  detail_cop_c: cover property (det_cop ##1 det_cop);
  single_pair_c: cover property (single_stb ##[1:8] single_stb);

endmodule : trace_entry_formatter
`default_nettype wire

// ==== shared/trace_fmt_pkg.sv ====
// constants, types and helpers shared by the trace entry formatter
//
// Overview of operation
// - detail mode: counter bit0 zero, rest counts lines
// - change of flow writes entry (line when both traced), sets source valid
// - other source pc stored as unflagged snapshot
// - detail byte access: low byte, high zeroed
// - word: lower address byte3, higher byte2
// - eight byte line, fixed detail field layout
// - cpu info bit7 marks destination address
// - vector bit6 forces source/destination bit set
// - cpu info bit4 marks valid cpu entry
// - combined info byte field order fixed
// - cpu detail skips fetch and free cycles
// - cpu detail: access type plus coprocessor qualifiers
// - coprocessor detail mirrors cpu, cpu snapshot
// - cpu free flag reads zero on free
package trace_fmt_pkg;

  // register port, bus monitor and line geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CPU_AW = 24;
  localparam int COP_AW = 16;
  localparam int ENTRY_W = 32;
  localparam int LINE_W = 64;

  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LINE_LO_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] LINE_HI_OFS = 8'h0c;

  // control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CPU_BIT = 3;
  localparam int CTRL_COP_BIT = 4;
  localparam int CTRL_CLR_BIT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // information byte fields
  localparam int INF_SD_BIT = 7;
  localparam int INF_VEC_BIT = 6;
  localparam int INF_VALID_BIT = 4;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LOOP = 2'h1,
    MODE_PURE_PC = 2'h2,
    MODE_DETAIL = 2'h3
  } trace_mode_type;

  typedef enum logic [1:0] {
    PACK_EMPTY = 2'b01,
    PACK_HALF = 2'b10
  } pack_state_type;

  // info byte of one source for the non-detail modes
  function automatic logic [7:0] info_byte(input trace_mode_type mode,
      input logic dest, input logic vec, input logic valid);
    logic [7:0] b;
    logic flow_mode;
    b = 8'h00;
    flow_mode = (mode == MODE_NORMAL) || (mode == MODE_LOOP);
    b[INF_SD_BIT] = flow_mode & (dest | vec);
    b[INF_VEC_BIT] = flow_mode & vec;
    b[INF_VALID_BIT] = valid;
    return b;
  endfunction : info_byte

  // data bytes 3:2, byte3 from the lower address
  function automatic logic [15:0] data_lanes(input logic word,
      input logic [15:0] d);
    return word ? d : {8'h00, d[7:0]};
  endfunction : data_lanes

endpackage : trace_fmt_pkg

// ==== shared/trace_entry_if.sv ====
// carrier between the formatter and its entry pair packer
`timescale 1ns/10ps
`default_nettype none
interface trace_entry_if;
  logic [trace_fmt_pkg::ENTRY_W-1:0] entry;
  logic entry_stb;
  logic flush;
  logic [trace_fmt_pkg::LINE_W-1:0] line;
  logic line_stb;
  modport feeder(output entry, output entry_stb, output flush,
    input line, input line_stb);
  modport packer(input entry, input entry_stb, input flush,
    output line, output line_stb);
endinterface : trace_entry_if
`default_nettype wire

// ==== hw/info_byte_builder.sv ====
// builds the cpu, coprocessor and combined information bytes
`timescale 1ns/10ps
`default_nettype none
module info_byte_builder (
  // clock and reset, used by the checker only
  input wire logic ref_clk,
  input wire logic rst,
  // mode
  input wire trace_fmt_pkg::trace_mode_type mode,
  // cpu qualifiers
  input wire logic cpu_dest,
  input wire logic cpu_vector,
  input wire logic cpu_valid,
  input wire logic cpu_free,
  input wire logic cpu_access_size,
  input wire logic cpu_read_write,
  input wire logic cpu_opcode_fetch,
  // coprocessor qualifiers
  input wire logic cop_dest,
  input wire logic cop_vector,
  input wire logic cop_valid,
  input wire logic cop_bus_ack,
  input wire logic cop_access_size,
  input wire logic cop_read_write,
  input wire logic cop_opcode_fetch,
  // bytes
  output logic [7:0] cpu_info_byte,
  output logic [7:0] cop_info_byte,
  output logic [7:0] combined_info_byte
);
  import trace_fmt_pkg::*;

  // per-source bytes share one format
  assign cpu_info_byte = info_byte(mode, cpu_dest, cpu_vector, cpu_valid);
  assign cop_info_byte = info_byte(mode, cop_dest, cop_vector, cop_valid);

  // detail byte; free flag inverted so zero means free
  assign combined_info_byte = {~cpu_free, cpu_access_size,
    cpu_read_write, cpu_opcode_fetch, cop_bus_ack,
    cop_access_size, cop_read_write, cop_opcode_fetch};

  // sampled on the system clock so the check sees settled bytes only
  vector_implies_dest_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    cpu_info_byte[INF_VEC_BIT] |-> cpu_info_byte[INF_SD_BIT])
    else $error("vector flag set without destination flag");

endmodule : info_byte_builder
`default_nettype wire

// ==== hw/pc_pair_packer.sv ====
// packs two single-source entries into one eight byte line
`timescale 1ns/10ps
`default_nettype none
module pc_pair_packer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // entries in, lines out
  trace_entry_if.packer ent
);
  import trace_fmt_pkg::*;

  pack_state_type state_q;
  pack_state_type state_d;
  logic [ENTRY_W-1:0] held_q;
  logic take_first;

  // first entry lands in bytes 3:0, second completes the line
  assign take_first = ent.entry_stb && !ent.flush &&
    (state_q == PACK_EMPTY);
  assign ent.line_stb = ent.entry_stb && !ent.flush &&
    (state_q == PACK_HALF);
  assign ent.line = {ent.entry, held_q};

  // a flush drops a lone half so stale entries never pair up
  always_comb begin
    case (state_q)
      PACK_EMPTY: state_d = take_first ? PACK_HALF : PACK_EMPTY;
      PACK_HALF: state_d = (ent.flush || ent.entry_stb) ? PACK_EMPTY
        : PACK_HALF;
      default: state_d = PACK_EMPTY;
    endcase
  end

  // state and held entry
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= PACK_EMPTY;
      held_q <= '0;
    end else begin
      state_q <= state_d;
      if (take_first) begin
        held_q <= ent.entry;
      end
    end
  end

  pair_line_a: assert property (@(posedge ref_clk) disable iff (rst)
    (take_first ##1 (ent.entry_stb && !ent.flush)) |->
    (ent.line_stb && ent.line[ENTRY_W-1:0] == $past(ent.entry)))
    else $error("second entry did not complete the pair");

endmodule : pc_pair_packer
`default_nettype wire

// ==== test/bus_monitor_model.sv ====
// far-side model of the cpu and coprocessor bus monitors
`timescale 1ns/10ps
`default_nettype none
module bus_monitor_model (
  // clock
  input wire logic ref_clk,
  // cpu monitor
  output logic [23:0] cpu_pc,
  output logic [6:0] cpu_flags,
  output logic [23:0] cpu_addr,
  output logic [15:0] cpu_data,
  // coprocessor monitor
  output logic [15:0] cop_pc,
  output logic [6:0] cop_flags,
  output logic [15:0] cop_addr,
  output logic [15:0] cop_data
);
  // flags: change of flow, dest, vector, free or ack, fetch, size, rw
  initial begin
    cpu_pc = 24'h000000;
    cpu_flags = 7'h08;
    cpu_addr = 24'h000000;
    cpu_data = 16'h0000;
    cop_pc = 16'h0000;
    cop_flags = 7'h00;
    cop_addr = 16'h0000;
    cop_data = 16'h0000;
  end

  // one monitored cycle of both masters, driven after the edge
  task automatic cyc(input logic [23:0] cp, input logic [6:0] cf,
      input logic [23:0] ca, input logic [15:0] cd, input logic [15:0] xp,
      input logic [6:0] xf, input logic [15:0] xa, input logic [15:0] xd);
    @(posedge ref_clk);
    cpu_pc <= cp;
    cpu_flags <= cf;
    cpu_addr <= ca;
    cpu_data <= cd;
    cop_pc <= xp;
    cop_flags <= xf;
    cop_addr <= xa;
    cop_data <= xd;
  endtask : cyc

  // free cycle on both; released buses flip so stale data cannot match
  task automatic idle();
    @(posedge ref_clk);
    cpu_flags <= 7'h08;
    cop_flags <= 7'h00;
    cpu_addr <= ~cpu_addr;
    cpu_data <= ~cpu_data;
    cop_addr <= ~cop_addr;
    cop_data <= ~cop_data;
  endtask : idle
endmodule : bus_monitor_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the trace entry formatter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import trace_fmt_pkg::*;
  logic ref_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [23:0] cpu_pc, cpu_addr;
  logic [6:0] cf, xf;
  logic [15:0] cpu_data, cop_pc, cop_addr, cop_data;
  logic [63:0] trace_line;
  logic trace_line_wr;
  logic [6:0] trace_entry_counter;
  logic [63:0] lines[$];
  logic [31:0] rv;
  int n_errors = 0;
  int checks = 0;

  trace_entry_formatter #(.CNT_W(7)) uut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_pc(cpu_pc),
    .cpu_change_of_flow(cf[6]), .cpu_dest(cf[5]), .cpu_vector(cf[4]),
    .cpu_free(cf[3]), .cpu_opcode_fetch(cf[2]), .cpu_addr(cpu_addr),
    .cpu_access_size(cf[1]), .cpu_read_write(cf[0]), .cpu_data(cpu_data),
    .cop_pc(cop_pc), .cop_change_of_flow(xf[6]), .cop_dest(xf[5]),
    .cop_vector(xf[4]), .cop_bus_ack(xf[3]), .cop_opcode_fetch(xf[2]),
    .cop_addr(cop_addr), .cop_access_size(xf[1]),
    .cop_read_write(xf[0]), .cop_data(cop_data), .trace_line(trace_line),
    .trace_line_wr(trace_line_wr),
    .trace_entry_counter(trace_entry_counter));

  bus_monitor_model m (.ref_clk(ref_clk), .cpu_pc(cpu_pc),
    .cpu_flags(cf), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
    .cop_pc(cop_pc), .cop_flags(xf), .cop_addr(cop_addr),
    .cop_data(cop_data));

  // 25 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // collect every written line; the strobe stands one cycle per line, so back-to-back lines hold it high for several cycles
  always @(posedge ref_clk) begin
    if (trace_line_wr === 1'b1) lines.push_back(trace_line);
  end

  task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd

  // new control word clears the counter and any half line
  task automatic start(input logic [31:0] ctrl);
    wr(CTRL_OFS, ctrl);
    lines.delete();
  endtask : start

  task automatic settle();
    repeat (3) m.idle();
  endtask : settle

  task automatic test_reset();
    chk("line after reset", 64'h0, trace_line);
    chk("counter after reset", 64'h0, 64'(trace_entry_counter));
    rd(CTRL_OFS, rv);
    chk("ctrl reset", 64'h0, 64'(rv));
    rd(8'h10, rv);
    chk("unmapped read", 64'h0, 64'(rv));
    $display("test reset done");
  endtask : test_reset

  // flow on one master snapshots the other, then both at once
  task automatic test_both();
    start(32'h39);
    m.cyc(24'h123456, 7'h70, 0, 0, 16'h4321, 7'h00, 0, 0);
    m.cyc(24'h00abcd, 7'h40, 0, 0, 16'h8888, 7'h60, 0, 0);
    m.cyc(24'h0000ee, 7'h08, 0, 0, 16'h5555, 7'h50, 0, 0);
    settle();
    chk("both lines", 64'd3, 64'(lines.size()));
    chk("cpu flow", {16'h0000, 16'h4321, 8'hd0, 24'h123456}, lines[0]);
    chk("both flow", {16'h9000, 16'h8888, 8'h10, 24'h00abcd}, lines[1]);
    chk("cop flow", {16'hd000, 16'h5555, 8'h00, 24'h0000ee}, lines[2]);
    chk("both count", 64'd3, 64'(trace_entry_counter));
    rd(LINE_LO_OFS, rv);
    chk("line low reg", 64'h000000ee, 64'(rv));
    rd(LINE_HI_OFS, rv);
    chk("line high reg", 64'hd0005555, 64'(rv));
    rd(CTRL_OFS, rv);
    chk("ctrl readback", 64'h19, 64'(rv));
    $display("test both done");
  endtask : test_both

  // single source: first entry held, second completes the line
  task automatic test_pair(input logic [31:0] ctrl, input logic [7:0] ia,
      input logic [7:0] ib);
    start(ctrl);
    m.cyc(24'h111111, 7'h60, 0, 0, 16'h0000, 7'h00, 0, 0);
    settle();
    chk("half line held", 64'd0, 64'(lines.size()));
    chk("half count", 64'd1, 64'(trace_entry_counter));
    m.cyc(24'h222222, 7'h40, 0, 0, 16'h0000, 7'h00, 0, 0);
    settle();
    chk("pair line", {ib, 24'h222222, ia, 24'h111111}, lines[0]);
    chk("pair count", 64'd2, 64'(trace_entry_counter));
    $display("test pair %h done", ctrl);
  endtask : test_pair

  // loop mode drops a repeat of the last stored pc
  task automatic test_loop();
    start(32'h2b);
    m.cyc(24'h0000c0, 7'h40, 0, 0, 16'h0, 7'h00, 0, 0);
    m.cyc(24'h0000c0, 7'h40, 0, 0, 16'h0, 7'h00, 0, 0);
    m.cyc(24'h0000d0, 7'h40, 0, 0, 16'h0, 7'h00, 0, 0);
    settle();
    chk("loop lines", 64'd1, 64'(lines.size()));
    chk("loop line", {8'h10, 24'h0000d0, 8'h10, 24'h0000c0}, lines[0]);
    $display("test loop done");
  endtask : test_loop

  // cpu detail: fetch and free cycles skipped, word and byte lanes
  task automatic test_detail_cpu();
    start(32'h2f);
    m.cyc(24'h345678, 7'h03, 24'h345678, 16'hbeef, 16'h7777, 7'h0c, 0, 0);
    m.cyc(24'h0, 7'h04, 24'h000020, 16'h1111, 16'h7777, 7'h08, 0, 0);
    m.cyc(24'h0, 7'h08, 24'h000030, 16'h2222, 16'h7777, 7'h08, 0, 0);
    m.cyc(24'h0, 7'h00, 24'h000010, 16'h55aa, 16'h7777, 7'h00, 0, 0);
    settle();
    chk("cpu detail lines", 64'd2, 64'(lines.size()));
    chk("cpu word", {8'he9, 24'h345678, 16'hbeef, 16'h7777}, lines[0]);
    chk("cpu byte", {8'h80, 24'h000010, 16'h00aa, 16'h7777}, lines[1]);
    chk("cpu detail count", 64'd4, 64'(trace_entry_counter));
    $display("test detail cpu done");
  endtask : test_detail_cpu

  // coprocessor detail: unacknowledged and fetch cycles skipped
  task automatic test_detail_cop();
    start(32'h37);
    m.cyc(24'h0c0c0c, 7'h08, 0, 0, 16'h0, 7'h0a, 16'h2468, 16'h1357);
    m.cyc(24'h0c0c0c, 7'h08, 0, 0, 16'h0, 7'h02, 16'h3000, 16'h3333);
    m.cyc(24'h0c0c0c, 7'h08, 0, 0, 16'h0, 7'h0c, 16'h4000, 16'h4444);
    m.cyc(24'h0c0c0c, 7'h04, 0, 0, 16'h0, 7'h09, 16'h2468, 16'hff42);
    settle();
    chk("cop detail lines", 64'd2, 64'(lines.size()));
    chk("cop word", {8'h0c, 24'h0c0c0c, 16'h1357, 16'h2468}, lines[0]);
    chk("cop byte", {8'h9a, 24'h0c0c0c, 16'h0042, 16'h2468}, lines[1]);
    chk("cop detail count", 64'd4, 64'(trace_entry_counter));
    $display("test detail cop done");
  endtask : test_detail_cop

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard well above the whole sequence
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("CHECK FAILED run time expected end seen timeout");
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_both();
    test_pair(32'h29, 8'h90, 8'h10);
    test_pair(32'h2d, 8'h10, 8'h10);
    test_loop();
    test_detail_cpu();
    test_detail_cop();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
